// *** rtl/wwdt_pkg.sv ***
// constants shared by the windowed watchdog design files
// assumes a 25 MHz system clock and a 32-bit avalon-mm register port
package wwdt_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int WARMUP_NS = 640;
    localparam int WARMUP_CYCLES = (WARMUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int PRESC_BASE_TAP = 8;
    localparam int PRESC_TAP_STEP = 2;
    localparam int PRESC_W = 16;

    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [4:0] CONFIG_OFS = 5'h00;
    localparam logic [4:0] CODE_OFS = 5'h04;
    localparam logic [4:0] COUNT_OFS = 5'h08;
    localparam logic [4:0] STATUS_OFS = 5'h0C;
    localparam logic [4:0] MASK_OFS = 5'h10;

    // config fields
    localparam int CFG_ENABLE_BIT = 0;
    localparam int CFG_ACTION_BIT = 1;
    localparam int CFG_WINDOW_LSB = 2;
    localparam int CFG_PERIOD_LSB = 4;
    localparam logic CFG_ENABLE_RST = 1'b1;
    localparam logic CFG_ACTION_RST = 1'b1;
    localparam logic [1:0] CFG_WINDOW_RST = 2'h0;
    localparam logic [1:0] CFG_PERIOD_RST = 2'h0;

    // status and mask fields
    localparam int ST_RUN_BIT = 0;
    localparam int ST_WINVIOL_BIT = 1;
    localparam int ST_OVF_BIT = 2;
    localparam logic [2:0] MASK_RST = 3'h0;

    // control codes
    localparam logic [7:0] CODE_CLEAR = 8'h4E;
    localparam logic [7:0] CODE_DISABLE = 8'hB1;

    // counter and window
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] WIN_START_01 = 8'h80;
    localparam logic [7:0] WIN_START_10 = 8'hC0;
    localparam logic [7:0] WIN_START_11 = 8'hE0;
endpackage

// *** rtl/wwdt_prescaler.sv ***
// source clock divider for the watchdog counter
// assumes run_i and tap_sel_i come from logic on the same clock
`timescale 1ns/1ps
module wwdt_prescaler #(
    parameter int PRESC_W = wwdt_pkg::PRESC_W,
    parameter int BASE_TAP = wwdt_pkg::PRESC_BASE_TAP,
    parameter int TAP_STEP = wwdt_pkg::PRESC_TAP_STEP
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic [1:0] tap_sel_i,
    // enable pulse out
    output logic tick_o
);
    typedef struct packed {
        logic [PRESC_W-1:0] div;
        logic tick;
    } wwdt_presc_state_t;

    wwdt_presc_state_t state_reg;
    wwdt_presc_state_t state_next;
    logic [PRESC_W-1:0] tap_mask;

    // ------------------------------------------------------------
    // tap decode: the tick fires when the low bits below the tap are all ones
    // ------------------------------------------------------------
    always_comb begin
        tap_mask = '0;
        for (int i = 0; i < PRESC_W; i++) begin
            if (i < BASE_TAP + TAP_STEP * int'(tap_sel_i)) begin
                tap_mask[i] = 1'b1;
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (!run_i || restart_i) begin
            // restart keeps the first period after a clear full length
            state_next.div = '0;
        end else begin
            state_next.div = state_reg.div + PRESC_W'(1);
            state_next.tick = ((state_reg.div & tap_mask) == tap_mask);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick_o = state_reg.tick;
endmodule

// *** rtl/wwdt_top.sv ***
// windowed watchdog: 8-bit up counter, control codes, status and interrupt
// assumes an avalon-mm master on clk_i and cpu logic taking nmi and reset pulses
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module wwdt_top #(
    parameter int WARMUP_CYCLES = wwdt_pkg::WARMUP_CYCLES,
    parameter int PRESC_BASE_TAP = wwdt_pkg::PRESC_BASE_TAP
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // avalon-mm slave
    input wire logic [4:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // requests to the cpu core
    output logic nmi_req_o,
    output logic chip_reset_req_o,
    output logic irq_o
);
    typedef struct packed {
        logic [15:0] warm;
        logic warm_done;
        logic enable;
        logic action;
        logic [1:0] window;
        logic [1:0] period;
        logic run;
        logic [7:0] count;
        logic [1:0] cause;
        logic [2:0] mask;
        logic [1:0] reported;
        logic busy;
        logic [31:0] rdata;
        logic nmi;
        logic rst_req;
        logic irq;
    } wwdt_state_t;

    wwdt_state_t state_reg;
    wwdt_state_t state_next;
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic tick;
    logic presc_restart;
    logic req;
    logic done;
    logic code_wr;
    logic clear_hit;
    logic disable_hit;
    logic early_clear;
    logic overflow;
    logic [1:0] cause_set;
    logic [2:0] status_view;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic in_window(input logic [1:0] sel, input logic [7:0] cnt);
        logic ok;
        case (sel)
            2'h0: ok = 1'b1;
            2'h1: ok = (cnt >= wwdt_pkg::WIN_START_01);
            2'h2: ok = (cnt >= wwdt_pkg::WIN_START_10);
            2'h3: ok = (cnt >= wwdt_pkg::WIN_START_11);
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction

    function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
        return addr == ofs;
    endfunction

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // assert at once, release two edges later to avoid a metastable release
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------
    // source clock divider
    // ------------------------------------------------------------
    // a lower base tap lets a short run reach several overflows
    wwdt_prescaler #(
        .BASE_TAP(PRESC_BASE_TAP)
    ) u_presc (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .run_i(state_reg.run),
        .restart_i(presc_restart),
        .tap_sel_i(state_reg.period),
        .tick_o(tick)
    );

    // ------------------------------------------------------------
    // bus decode and watchdog events
    // ------------------------------------------------------------
    always_comb begin
        req = read_i | write_i;
        done = req & !state_reg.busy;
        code_wr = done & write_i & byteenable_i[0] & hit(address_i, wwdt_pkg::CODE_OFS);
        clear_hit = code_wr && writedata_i[7:0] == wwdt_pkg::CODE_CLEAR && state_reg.run
            && in_window(state_reg.window, state_reg.count);
        early_clear = code_wr && writedata_i[7:0] == wwdt_pkg::CODE_CLEAR && state_reg.run
            && !in_window(state_reg.window, state_reg.count);
        disable_hit = code_wr && writedata_i[7:0] == wwdt_pkg::CODE_DISABLE
            && !state_reg.enable && state_reg.run;
        // a clear or a disable in the wrap cycle swallows the overflow
        overflow = tick && state_reg.run && state_reg.count == wwdt_pkg::COUNT_MAX
            && !clear_hit && !disable_hit;
        presc_restart = clear_hit | disable_hit;
        cause_set[1] = overflow & !state_reg.action;
        cause_set[0] = early_clear;
        status_view = {state_reg.cause, state_reg.run};
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.nmi = 1'b0;
        state_next.rst_req = 1'b0;

        // warm-up gate after reset release
        if (!state_reg.warm_done) begin
            if (state_reg.warm >= 16'(WARMUP_CYCLES - 1)) begin
                state_next.warm_done = 1'b1;
                state_next.run = state_reg.enable;
            end else begin
                state_next.warm = state_reg.warm + 16'h0001;
            end
        end

        // counter
        if (disable_hit) begin
            state_next.run = 1'b0;
            state_next.count = wwdt_pkg::COUNT_RST;
        end else if (clear_hit) begin
            state_next.count = wwdt_pkg::COUNT_RST;
        end else if (tick && state_reg.run) begin
            // wraps and keeps counting whichever action is set
            state_next.count = state_reg.count + 8'h01;
        end

        // requests: a fresh pulse per event, never masked
        if (overflow && !state_reg.action) begin
            state_next.nmi = 1'b1;
        end
        if (early_clear) begin
            state_next.nmi = 1'b1;
        end
        if (overflow && state_reg.action) begin
            state_next.rst_req = 1'b1;
        end

        // bus handshake: one wait cycle, data settles before release
        state_next.busy = !(req && state_reg.busy);
        if (req && state_reg.busy) begin
            state_next.rdata = 32'h0000_0000;
            if (read_i) begin
                case (address_i)
                    wwdt_pkg::CONFIG_OFS: begin
                        state_next.rdata[wwdt_pkg::CFG_ENABLE_BIT] = state_reg.enable;
                        state_next.rdata[wwdt_pkg::CFG_ACTION_BIT] = state_reg.action;
                        state_next.rdata[wwdt_pkg::CFG_WINDOW_LSB +: 2] = state_reg.window;
                        state_next.rdata[wwdt_pkg::CFG_PERIOD_LSB +: 2] = state_reg.period;
                    end
                    wwdt_pkg::COUNT_OFS: state_next.rdata[7:0] = state_reg.count;
                    wwdt_pkg::STATUS_OFS: state_next.rdata[2:0] = status_view;
                    wwdt_pkg::MASK_OFS: state_next.rdata[2:0] = state_reg.mask;
                    default: state_next.rdata = 32'h0000_0000;
                endcase
                // only the flags shown to software may be cleared by this read
                state_next.reported = hit(address_i, wwdt_pkg::STATUS_OFS) ? state_reg.cause : 2'h0;
            end
        end

        if (done && write_i && byteenable_i[0]) begin
            case (address_i)
                wwdt_pkg::CONFIG_OFS: begin
                    state_next.enable = writedata_i[wwdt_pkg::CFG_ENABLE_BIT];
                    state_next.action = writedata_i[wwdt_pkg::CFG_ACTION_BIT];
                    state_next.window = writedata_i[wwdt_pkg::CFG_WINDOW_LSB +: 2];
                    state_next.period = writedata_i[wwdt_pkg::CFG_PERIOD_LSB +: 2];
                    if (writedata_i[wwdt_pkg::CFG_ENABLE_BIT] && state_reg.warm_done) begin
                        state_next.run = 1'b1;
                    end
                end
                wwdt_pkg::MASK_OFS: state_next.mask = writedata_i[2:0];
                default: state_next.mask = state_reg.mask;
            endcase
        end

        // sticky causes, cleared by a status read, set wins
        if (done && read_i && hit(address_i, wwdt_pkg::STATUS_OFS)) begin
            state_next.cause = (state_reg.cause & ~state_reg.reported) | cause_set;
        end else begin
            state_next.cause = state_reg.cause | cause_set;
        end

        state_next.irq = |({state_next.cause, 1'b0} & state_next.mask);
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg.warm <= 16'h0000;
            state_reg.warm_done <= 1'b0;
            state_reg.enable <= wwdt_pkg::CFG_ENABLE_RST;
            state_reg.action <= wwdt_pkg::CFG_ACTION_RST;
            state_reg.window <= wwdt_pkg::CFG_WINDOW_RST;
            state_reg.period <= wwdt_pkg::CFG_PERIOD_RST;
            state_reg.run <= 1'b0;
            state_reg.count <= wwdt_pkg::COUNT_RST;
            state_reg.cause <= 2'h0;
            state_reg.mask <= wwdt_pkg::MASK_RST;
            state_reg.reported <= 2'h0;
            state_reg.busy <= 1'b1;
            state_reg.rdata <= 32'h0000_0000;
            state_reg.nmi <= 1'b0;
            state_reg.rst_req <= 1'b0;
            state_reg.irq <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign readdata_o = state_reg.rdata;
    assign waitrequest_o = state_reg.busy;
    assign nmi_req_o = state_reg.nmi;
    assign chip_reset_req_o = state_reg.rst_req;
    assign irq_o = state_reg.irq;
endmodule

// *** dv/wwdt_checker.sv ***
// port assertions for the windowed watchdog top
// assumes an avalon master that holds each request until waitrequest_o is low
`timescale 1ns/1ps
module wwdt_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // bus and requests
    input wire logic [4:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] readdata_o,
    input wire logic waitrequest_o,
    input wire logic nmi_req_o,
    input wire logic chip_reset_req_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic rd_done;
    logic irq_src;
    assign rd_done = read_i && !waitrequest_o;
    // only a status read or a mask write may pull the level down
    assign irq_src = !waitrequest_o && ((read_i && address_i == wwdt_pkg::STATUS_OFS)
        || (write_i && address_i == wwdt_pkg::MASK_OFS));
    chk_wait_one: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("waitrequest not low after first cycle");
    chk_wait_back: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    chk_nmi_pulse: assert property (nmi_req_o |=> !nmi_req_o)
        else $error("interrupt request longer than one cycle");
    chk_reset_pulse: assert property (chip_reset_req_o |=> !chip_reset_req_o)
        else $error("reset request longer than one cycle");
    chk_one_action: assert property (!(nmi_req_o && chip_reset_req_o))
        else $error("interrupt and reset requested together");
    chk_irq_drop: assert property ($fell(irq_o) |-> $past(irq_src) || $past(irq_src, 2))
        else $error("irq fell without status read or mask write");
    chk_code_reads: assert property (rd_done && (address_i == wwdt_pkg::CODE_OFS
        || address_i > wwdt_pkg::MASK_OFS) |-> readdata_o == 32'h0)
        else $error("write-only or unmapped read not zero");
    chk_count_width: assert property (rd_done && address_i == wwdt_pkg::COUNT_OFS |-> readdata_o[31:8] == 24'h0)
        else $error("count read has upper bits set");
    cov_nmi: cover property (nmi_req_o);
    cov_irq: cover property ($rose(irq_o));
    cov_rst: cover property (chip_reset_req_o);
endmodule
bind wwdt_top wwdt_checker wwdt_checker_i (.clk_i, .rst_n_i, .address_i, .read_i, .write_i, .readdata_o,
    .waitrequest_o, .nmi_req_o, .chip_reset_req_o, .irq_o);

// *** dv/wwdt_cpu_model.sv ***
// cpu core model: takes watchdog interrupt and reset request pulses
// assumes one-cycle request pulses on clk_i
`timescale 1ns/1ps
module wwdt_cpu_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // requests
    input wire logic nmi_req_i,
    input wire logic chip_reset_req_i,
    // counts of taken requests
    output logic [7:0] nmi_taken_o,
    output logic [7:0] reset_taken_o
);
    // no enable gate and no in-service block: every pulse nests one level deeper
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nmi_taken_o <= 8'h00;
            reset_taken_o <= 8'h00;
        end else begin
            if (nmi_req_i) begin
                nmi_taken_o <= nmi_taken_o + 8'h01;
            end
            if (chip_reset_req_i) begin
                reset_taken_o <= reset_taken_o + 8'h01;
            end
        end
    end
endmodule

// *** dv/windowed_watchdog_timer_bench.sv ***
// self-checking bench for the windowed watchdog top
// assumes the package offsets, a short warm-up and a short prescaler base tap
`timescale 1ns/1ps
module windowed_watchdog_timer_bench;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] address_i = 5'h00;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0;
    logic [3:0] byteenable_i = 4'hF;
    logic [31:0] readdata_o;
    logic waitrequest_o;
    logic nmi_req_o;
    logic chip_reset_req_o;
    logic irq_o;
    logic [7:0] nmi_taken;
    logic [7:0] reset_taken;
    logic [31:0] q;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    wwdt_top #(.WARMUP_CYCLES(2), .PRESC_BASE_TAP(2)) wwdt_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .nmi_req_o(nmi_req_o),
        .chip_reset_req_o(chip_reset_req_o), .irq_o(irq_o));
    wwdt_cpu_model wwdt_cpu_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .nmi_req_i(nmi_req_o),
        .chip_reset_req_i(chip_reset_req_o), .nmi_taken_o(nmi_taken), .reset_taken_o(reset_taken));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task close_out;
        if (err_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // a full run needs about 9k cycles with the short base tap
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            close_out;
        end
    end
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one avalon transfer; the edge first keeps strobes from being set twice in a step
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        address_i <= a;
        writedata_i <= d;
        write_i <= wr;
        read_i <= !wr;
        @(posedge clk_i);
        while (waitrequest_o !== 1'b0 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        q = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
        if (n >= 100) chk("waitrequest", 32'h0, 32'h1);
    endtask
    task rd(input string name, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(name, exp, q);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd("config", wwdt_pkg::CONFIG_OFS, 32'h3);
        rd("status", wwdt_pkg::STATUS_OFS, 32'h1);
        rd("mask", wwdt_pkg::MASK_OFS, 32'h0);
        bus(1'b1, 5'h14, 32'hFF);
        rd("unmapped", 5'h14, 32'h0);
        // period 11 on the short base tap: one tick each 256 clocks
        bus(1'b1, wwdt_pkg::CONFIG_OFS, 32'h31);
        bus(1'b1, wwdt_pkg::CODE_OFS, {24'h0, wwdt_pkg::CODE_CLEAR});
        rd("count cleared", wwdt_pkg::COUNT_OFS, 32'h0);
        repeat (520) @(posedge clk_i);
        rd("count runs", wwdt_pkg::COUNT_OFS, 32'h2);
        // window 11 with the count far below the window opening
        bus(1'b1, wwdt_pkg::MASK_OFS, 32'h2);
        bus(1'b1, wwdt_pkg::CONFIG_OFS, 32'h3D);
        bus(1'b1, wwdt_pkg::CODE_OFS, {24'h0, wwdt_pkg::CODE_CLEAR});
        repeat (3) @(posedge clk_i);
        chk("nmi early", 32'h1, {24'h0, nmi_taken});
        chk("irq early", 32'h1, {31'h0, irq_o});
        rd("count kept", wwdt_pkg::COUNT_OFS, 32'h2);
        rd("status viol", wwdt_pkg::STATUS_OFS, 32'h3);
        repeat (3) @(posedge clk_i);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        rd("status read", wwdt_pkg::STATUS_OFS, 32'h1);
        bus(1'b1, wwdt_pkg::CONFIG_OFS, 32'h1);
        bus(1'b1, wwdt_pkg::CODE_OFS, {24'h0, wwdt_pkg::CODE_DISABLE});
        rd("status no dis", wwdt_pkg::STATUS_OFS, 32'h1);
        bus(1'b1, wwdt_pkg::CONFIG_OFS, 32'h0);
        bus(1'b1, wwdt_pkg::CODE_OFS, {24'h0, wwdt_pkg::CODE_DISABLE});
        rd("status dis", wwdt_pkg::STATUS_OFS, 32'h0);
        rd("count dis", wwdt_pkg::COUNT_OFS, 32'h0);
        // period 01: a tick each 16 clocks, so the wrapped count still reads zero
        bus(1'b1, wwdt_pkg::CONFIG_OFS, 32'h11);
        rd("status re-en", wwdt_pkg::STATUS_OFS, 32'h1);
        bus(1'b1, wwdt_pkg::MASK_OFS, 32'h4);
        bus(1'b1, wwdt_pkg::CODE_OFS, {24'h0, wwdt_pkg::CODE_CLEAR});
        while (nmi_taken == 8'h01) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        chk("nmi ovf", 32'h2, {24'h0, nmi_taken});
        chk("no reset", 32'h0, {24'h0, reset_taken});
        chk("irq ovf", 32'h1, {31'h0, irq_o});
        rd("status ovf", wwdt_pkg::STATUS_OFS, 32'h5);
        rd("count wrap", wwdt_pkg::COUNT_OFS, 32'h0);
        // period 00: the wrap lands 1025 edges after a clear; each request below completes on it
        bus(1'b1, wwdt_pkg::CONFIG_OFS, 32'h1);
        bus(1'b1, wwdt_pkg::CODE_OFS, {24'h0, wwdt_pkg::CODE_CLEAR});
        repeat (1022) @(posedge clk_i);
        rd("status at ovf", wwdt_pkg::STATUS_OFS, 32'h1);
        rd("status kept", wwdt_pkg::STATUS_OFS, 32'h5);
        chk("nmi third", 32'h3, {24'h0, nmi_taken});
        bus(1'b1, wwdt_pkg::CODE_OFS, {24'h0, wwdt_pkg::CODE_CLEAR});
        repeat (1022) @(posedge clk_i);
        bus(1'b1, wwdt_pkg::CODE_OFS, {24'h0, wwdt_pkg::CODE_CLEAR});
        repeat (3) @(posedge clk_i);
        chk("nmi clear wins", 32'h3, {24'h0, nmi_taken});
        rd("status clear wins", wwdt_pkg::STATUS_OFS, 32'h1);
        bus(1'b1, wwdt_pkg::CODE_OFS, {24'h0, wwdt_pkg::CODE_CLEAR});
        bus(1'b1, wwdt_pkg::CONFIG_OFS, 32'h0);
        repeat (1019) @(posedge clk_i);
        bus(1'b1, wwdt_pkg::CODE_OFS, {24'h0, wwdt_pkg::CODE_DISABLE});
        repeat (3) @(posedge clk_i);
        chk("nmi dis wins", 32'h3, {24'h0, nmi_taken});
        rd("status dis wins", wwdt_pkg::STATUS_OFS, 32'h0);
        rd("count dis wins", wwdt_pkg::COUNT_OFS, 32'h0);
        // reset action: the request pulses, no cause flag is kept
        bus(1'b1, wwdt_pkg::CONFIG_OFS, 32'h3);
        while (reset_taken == 8'h00) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        chk("reset ovf", 32'h1, {24'h0, reset_taken});
        chk("nmi none", 32'h3, {24'h0, nmi_taken});
        rd("status reset", wwdt_pkg::STATUS_OFS, 32'h1);
        close_out;
    end
endmodule
